// File: rtl/switch_detect_global_config.sv
// serial link, global configuration and link check of the switch detect device
//
// Behaviour
// R1 - link check read returns 0x123456 next frame
// R2 - link check response never clears interrupt flag
// R3 - frame: address 31-25, write 24, data 23-0
// R4 - overvoltage, guard on: limit 2 mA, block sleep
// R5 - guard off bit keeps normal operation
// R6 - overvoltage flag set on entry always
// R7 - qualify bit 0: no wake on falling edge
// R8 - qualify bit 1: wake on any falling edge
// R9 - interrupt pin latched low or pulsed low
// R10 - bits 7-0 pick battery or ground type
// R11 - closed programmable input always reports one
// R12 - bit 13 picks 1 ms or 55 us polling
// R13 - type bits writable anytime in normal mode
// R14 - config reply: fault 23, flag 22, data
// R15 - unused config bits zero after reset
// R16 - top reply bit shows fault summary
// R17 - write flag one writes, zero only reads
// R18 - reset restores all configuration defaults
`timescale 1ns/10ps
module switch_detect_global_config #(
  parameter int POLL_SLOW_CYC = swcfg_pkg::POLL_SLOW_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // serial link pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // device pins and analog status
  input wire logic wake_pin_n_in,
  input wire logic logic_supply_ok_in,
  input wire logic battery_overvoltage_in,
  input wire logic [7:0] programmable_input_level_in,
  // events from the rest of the device
  input wire logic fault_in,
  input wire logic interrupt_event_in,
  input wire logic low_power_state_in,
  // controls and status
  output logic wetting_limit_out,
  output logic low_power_allowed_out,
  output logic overvoltage_flag_out,
  output logic wake_request_out,
  output logic interrupt_pin_n_out,
  output logic battery_poll_tick_out,
  output logic [7:0] programmable_input_closed_out,
  output logic [23:0] config_out
);
  logic [13:0] sync_level;
  logic sclk_f, cs_n_f, mosi_f, wake_f, supply_f, ov_f;
  logic [7:0] level_f;
  logic sclk_d, wake_d, ov_d;
  swcfg_pkg::serial_t ser, next_ser;
  logic [23:0] cfg, next_cfg;
  logic interrupt_flag, next_interrupt_flag;
  logic next_ov_flag;
  logic [15:0] pulse_cnt, next_pulse_cnt;
  logic [15:0] poll_cnt, next_poll_cnt;
  logic frame_done, sclk_rise, sclk_fall, wake_fall, ov_rise, int_pulse_mode;
  logic [6:0] addr;
  logic write_req;
  logic [31:0] resp;
  logic [15:0] poll_limit;

  pin_sync3 #(.WIDTH(swcfg_pkg::SYNC_WIDTH)) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in({sclk_in, ~cs_n_in, mosi_in, ~wake_pin_n_in, logic_supply_ok_in,
               battery_overvoltage_in, programmable_input_level_in}),
    .level_out(sync_level)
  );

  assign {sclk_f, cs_n_f, mosi_f, wake_f, supply_f, ov_f, level_f} =
    {sync_level[13], ~sync_level[12], sync_level[11:0]};
  assign sclk_rise = sclk_f & ~sclk_d;
  assign sclk_fall = ~sclk_f & sclk_d;
  assign wake_fall = wake_f & ~wake_d;
  assign ov_rise = ov_f & ~ov_d;
  assign frame_done = (ser.state == swcfg_pkg::LINK_SHIFT) && cs_n_f &&
                      (ser.count == 6'(swcfg_pkg::FRAME_BITS));
  assign addr = ser.shift_in[swcfg_pkg::ADDR_MSB:swcfg_pkg::ADDR_LSB]; // R3
  assign write_req = ser.shift_in[swcfg_pkg::RW_BIT]; // R3
  assign int_pulse_mode = cfg[swcfg_pkg::POS_INT_PULSE_MODE];

  // reply built for the frame after this one
  always_comb begin
    resp = {8'h00, fault_in | overvoltage_flag_out, next_interrupt_flag, 22'h000000}; // R16
    if (addr == swcfg_pkg::ADDR_LINK_CHECK) begin
      resp = {8'h00, swcfg_pkg::LINK_PATTERN}; // R1 R2
    end else if (addr == swcfg_pkg::ADDR_GLOBAL_CONFIG) begin
      resp[21:0] = next_cfg[21:0]; // R14
    end
  end

  // serial shifter
  always_comb begin
    next_ser = ser;
    unique case (ser.state)
      swcfg_pkg::LINK_IDLE: begin
        if (!cs_n_f) begin
          next_ser.state = swcfg_pkg::LINK_SHIFT;
          next_ser.count = 6'h00;
        end
      end
      swcfg_pkg::LINK_SHIFT: begin
        if (cs_n_f) begin
          next_ser.state = swcfg_pkg::LINK_IDLE;
          if (frame_done) begin
            next_ser.shift_out = resp;
            // only a reply that showed the flag set may clear it later
            next_ser.resp_has_flag = resp[swcfg_pkg::POS_INT_FLAG]; // R2
          end
        end else if (sclk_rise) begin
          next_ser.shift_in = {ser.shift_in[30:0], mosi_f};
          if (ser.count != 6'(swcfg_pkg::FRAME_BITS + 1)) begin
            next_ser.count = ser.count + 6'h01;
          end
        end else if (sclk_fall) begin
          next_ser.shift_out = {ser.shift_out[30:0], 1'b0};
        end
      end
    endcase
  end

  // configuration register and flags
  always_comb begin
    next_cfg = cfg;
    if (frame_done && write_req && addr == swcfg_pkg::ADDR_GLOBAL_CONFIG &&
        !low_power_state_in) begin // R13 R17
      next_cfg = ser.shift_in[23:0] & swcfg_pkg::CFG_WRITE_MASK; // R10 R15
    end
    next_interrupt_flag = interrupt_flag;
    if (frame_done && ser.resp_has_flag) begin
      next_interrupt_flag = 1'b0;
    end
    if (interrupt_event_in) begin
      next_interrupt_flag = 1'b1;
    end
    next_ov_flag = overvoltage_flag_out;
    if (frame_done && !ov_f) begin
      next_ov_flag = 1'b0;
    end
    if (ov_rise) begin
      next_ov_flag = 1'b1; // R6
    end
    next_pulse_cnt = pulse_cnt;
    if (interrupt_event_in && int_pulse_mode) begin
      next_pulse_cnt = 16'(swcfg_pkg::INT_PULSE_CYC);
    end else if (pulse_cnt != 16'h0000) begin
      next_pulse_cnt = pulse_cnt - 16'h0001;
    end
    poll_limit = cfg[swcfg_pkg::POS_POLL_SEL] ? 16'(swcfg_pkg::POLL_FAST_CYC) :
                 16'(POLL_SLOW_CYC); // R12
    next_poll_cnt = (poll_cnt + 16'h0001 >= poll_limit) ? 16'h0000 : poll_cnt + 16'h0001;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ser <= '{swcfg_pkg::LINK_IDLE, 32'h00000000, 32'h00000000, 6'h00, 1'b0};
      cfg <= swcfg_pkg::CFG_RESET; // R18
      interrupt_flag <= 1'b0;
      overvoltage_flag_out <= 1'b0;
      pulse_cnt <= 16'h0000;
      poll_cnt <= 16'h0000;
      sclk_d <= 1'b0;
      wake_d <= 1'b0;
      ov_d <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
      wetting_limit_out <= 1'b0;
      low_power_allowed_out <= 1'b1;
      wake_request_out <= 1'b0;
      interrupt_pin_n_out <= 1'b1;
      battery_poll_tick_out <= 1'b0;
      programmable_input_closed_out <= 8'h00;
      config_out <= swcfg_pkg::CFG_RESET;
    end else begin
      ser <= next_ser;
      cfg <= next_cfg;
      interrupt_flag <= next_interrupt_flag;
      overvoltage_flag_out <= next_ov_flag;
      pulse_cnt <= next_pulse_cnt;
      poll_cnt <= next_poll_cnt;
      sclk_d <= sclk_f;
      wake_d <= wake_f;
      ov_d <= ov_f;
      miso_out <= next_ser.shift_out[31];
      miso_oe_out <= !cs_n_f;
      wetting_limit_out <= ov_f && !cfg[swcfg_pkg::POS_OV_GUARD_OFF]; // R4 R5
      low_power_allowed_out <= !(ov_f && !cfg[swcfg_pkg::POS_OV_GUARD_OFF]); // R4 R5
      wake_request_out <= wake_fall && cfg[swcfg_pkg::POS_WAKE_QUALIFY]; // R7 R8
      interrupt_pin_n_out <= int_pulse_mode ? (next_pulse_cnt == 16'h0000) :
                             !next_interrupt_flag; // R9
      battery_poll_tick_out <= (next_poll_cnt == 16'h0000);
      programmable_input_closed_out <= ~(level_f ^ cfg[7:0]); // R11
      config_out <= next_cfg;
    end
  end

  sequence s_link_check_frame;
    frame_done && addr == swcfg_pkg::ADDR_LINK_CHECK && !write_req;
  endsequence

  a_link_pattern: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_link_check_frame |=> ser.shift_out == 32'h00123456) // R1
    else $error("link check reply wrong");
  a_link_keeps_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_link_check_frame |=> !ser.resp_has_flag) // R2
    else $error("link check reply may clear flag");
  a_flag_kept: assert property (@(posedge core_clk_in) disable iff (rst_in)
    interrupt_flag && frame_done && !ser.resp_has_flag |=> interrupt_flag) // R2
    else $error("flag cleared by link check");
  a_wetting_cap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ov_f && !cfg[12] && $stable(cfg) |=> wetting_limit_out && !low_power_allowed_out) // R4
    else $error("overvoltage limit missing");
  a_guard_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cfg[12] && $stable(cfg) |=> !wetting_limit_out && low_power_allowed_out) // R5
    else $error("guard off not honoured");
  a_ov_flag_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ov_rise |=> overvoltage_flag_out) // R6
    else $error("overvoltage flag not set");
  a_wake_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wake_fall |=> wake_request_out == $past(cfg[11])) // R7 R8
    else $error("wake qualify wrong");
  a_int_latch: assert property (@(posedge core_clk_in) disable iff (rst_in)
    interrupt_event_in && !int_pulse_mode ##1 !int_pulse_mode |-> !interrupt_pin_n_out) // R9
    else $error("latched interrupt pin not low");
  a_cfg_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    frame_done && write_req && addr == 7'h01 && !low_power_state_in
    |=> cfg == ($past(ser.shift_in[23:0]) & 24'h003cff)) // R13 R15 R17
    else $error("config write wrong");
  a_cfg_reply: assert property (@(posedge core_clk_in) disable iff (rst_in)
    frame_done && addr == 7'h01 |=> ser.shift_out[21:0] == cfg[21:0]) // R14
    else $error("config reply wrong");
endmodule // switch_detect_global_config

// File: rtl/swcfg_pkg.sv
// package: constants and types of the switch detect global configuration block
package swcfg_pkg;
  localparam int FRAME_BITS = 32;
  localparam logic [6:0] ADDR_LINK_CHECK = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL_CONFIG = 7'h01;
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 25;
  localparam int RW_BIT = 24;
  localparam logic [23:0] LINK_PATTERN = 24'h123456;
  localparam logic [23:0] CFG_RESET = 24'h0008ff;
  localparam logic [23:0] CFG_WRITE_MASK = 24'h003cff;
  localparam int POS_FAULT = 23;
  localparam int POS_INT_FLAG = 22;
  localparam int POS_POLL_SEL = 13;
  localparam int POS_OV_GUARD_OFF = 12;
  localparam int POS_WAKE_QUALIFY = 11;
  localparam int POS_INT_PULSE_MODE = 10;
  localparam int CLK_MHZ = 50;
  localparam int POLL_SLOW_US = 1000;
  localparam int POLL_FAST_NS = 55000;
  localparam int INT_PULSE_NS = 10000;
  localparam int POLL_SLOW_CYC = POLL_SLOW_US * CLK_MHZ;
  localparam int POLL_FAST_CYC = POLL_FAST_NS * CLK_MHZ / 1000;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_WIDTH = 14;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_SHIFT = 2'b10
  } link_state_t;

  typedef struct packed {
    link_state_t state;
    logic [31:0] shift_in;
    logic [31:0] shift_out;
    logic [5:0] count;
    logic resp_has_flag;
  } serial_t;
endpackage

// File: rtl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1, stage2, stage3, next_level;

  always_comb begin
    next_level = level_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level_out <= next_level;
    end
  end
endmodule // pin_sync3

// File: bench/spi_host_model.sv
// host side serial master model for the configuration link
`timescale 1ns/10ps
module spi_host_model (
  // clock
  input wire logic core_clk_in,
  // serial link
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  task automatic wt(input int k);
    repeat (k) @(negedge core_clk_in);
  endtask

  // one 32-bit frame, msb first, clock idle low
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n_out = 1'b0;
    wt(8);
    for (int i = 31; i >= 0; i--) begin
      mosi_out = tx[i];
      wt(4);
      sclk_out = 1'b1;
      wt(4);
      // miso sampled just before the fall that moves it on
      rx[i] = miso_in;
      sclk_out = 1'b0;
    end
    wt(4);
    cs_n_out = 1'b1;
    // released data line shows the inverse of its last bit
    mosi_out = ~tx[0];
    wt(12);
  endtask
endmodule // spi_host_model

// File: bench/tb.sv
// self-checking bench for the switch detect global configuration block
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wake_n = 1'b1;
  logic ov = 1'b0;
  logic ev = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic lps = 1'b0;
  logic sclk, cs_n, mosi, miso, oe, wet, lp_ok, ov_flag, wake_req, int_n, tick;
  logic [7:0] closed;
  logic [23:0] cfg;
  logic [31:0] rx;
  int mismatches = 0;
  int checked = 0;
  int wakes = 0;
  int oe_cycles = 0;
  int n;

  always #10 clk = ~clk;
  always @(posedge clk) if (wake_req === 1'b1) wakes <= wakes + 1;
  always @(posedge clk) if (oe === 1'b1) oe_cycles <= oe_cycles + 1;

  switch_detect_global_config #(.POLL_SLOW_CYC(200)) switch_detect_global_config_i (
    .core_clk_in(clk), .rst_in(rst), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_out(oe), .wake_pin_n_in(wake_n), .logic_supply_ok_in(1'b1),
    .battery_overvoltage_in(ov), .programmable_input_level_in(lvl), .fault_in(1'b0),
    .interrupt_event_in(ev), .low_power_state_in(lps), .wetting_limit_out(wet),
    .low_power_allowed_out(lp_ok), .overvoltage_flag_out(ov_flag),
    .wake_request_out(wake_req), .interrupt_pin_n_out(int_n),
    .battery_poll_tick_out(tick), .programmable_input_closed_out(closed),
    .config_out(cfg));

  spi_host_model spi_host_model_i (.core_clk_in(clk), .miso_in(miso), .sclk_out(sclk),
    .cs_n_out(cs_n), .mosi_out(mosi));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic cf(input logic w, input logic [23:0] d);
    spi_host_model_i.xfer({swcfg_pkg::ADDR_GLOBAL_CONFIG, w, d}, rx);
  endtask

  task automatic pulse_event;
    ev = 1'b1;
    wt(1);
    ev = 1'b0;
  endtask

  // cycles between two poll ticks
  task automatic tick_gap(output int g);
    for (g = 0; tick !== 1'b1 && g < 4000; g++) wt(1);
    g = 0;
    do begin
      wt(1);
      g++;
    end while (tick !== 1'b1 && g < 4000);
  endtask

  task automatic final_report;
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #1500000;
    mismatches++;
    final_report;
  end

  initial begin
    wt(10);
    rst = 1'b0;
    wt(6);
    chk(cfg, swcfg_pkg::CFG_RESET);
    chk(int_n, 1'b1);
    chk(oe, 1'b0);
    spi_host_model_i.xfer({swcfg_pkg::ADDR_LINK_CHECK, 1'b0, 24'h0}, rx);
    // output enable stands exactly as long as chip select is low
    chk(oe_cycles, 268);
    cf(1'b0, 24'h0);
    chk(rx, {8'h00, swcfg_pkg::LINK_PATTERN});
    cf(1'b1, 24'hffffff);
    chk(rx, {8'h00, 2'b00, swcfg_pkg::CFG_RESET[21:0]});
    chk(cfg, swcfg_pkg::CFG_WRITE_MASK);
    cf(1'b0, 24'h0);
    cf(1'b0, 24'h0);
    chk(rx, {8'h00, 2'b00, 22'h003cff});
    chk(cfg, 24'h003cff);
    tick_gap(n);
    chk(n, swcfg_pkg::POLL_FAST_CYC);
    cf(1'b1, 24'h0000f0);
    tick_gap(n);
    chk(n, 200);
    lvl = 8'h3c;
    wake_n = 1'b0;
    wt(20);
    chk(closed, 8'h33);
    chk(wakes, 0);
    wake_n = 1'b1;
    ov = 1'b1;
    wt(20);
    chk({wet, lp_ok, ov_flag}, 3'b101);
    cf(1'b1, 24'h0018f0);
    chk({wet, lp_ok, ov_flag}, 3'b011);
    wake_n = 1'b0;
    wt(20);
    chk(wakes, 1);
    cf(1'b0, 24'h0);
    pulse_event;
    wt(2);
    chk(int_n, 1'b0);
    spi_host_model_i.xfer({swcfg_pkg::ADDR_LINK_CHECK, 1'b0, 24'h0}, rx);
    cf(1'b0, 24'h0);
    chk(rx, {8'h00, swcfg_pkg::LINK_PATTERN});
    chk(int_n, 1'b0);
    cf(1'b1, 24'h001cf0);
    chk(rx, {8'h00, 2'b11, 22'h0018f0});
    chk(int_n, 1'b1);
    pulse_event;
    for (n = 0; int_n !== 1'b0 && n < 10; n++) wt(1);
    for (n = 0; int_n === 1'b0 && n < 1000; n++) wt(1);
    chk(n, swcfg_pkg::INT_PULSE_CYC);
    // writes outside normal mode are refused
    lps = 1'b1;
    cf(1'b1, 24'h000000);
    chk(cfg, 24'h001cf0);
    lps = 1'b0;
    final_report;
  end
endmodule // tb
